// ===== verilog/synth_pll_cfg.svh
// Register offsets, field positions and reset values of the synthesizer control bank
`ifndef SYNTH_PLL_CFG_SVH
`define SYNTH_PLL_CFG_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ADDR_SYNTH_GENERAL_CONTROL 8'h2e
`define ADDR_SYNTH_REF_CLOCK_MHZ_FIELD_A 8'h2f
`define ADDR_SYNTH_IRQ_ENABLE 8'h31
`define ADDR_SYNTH_IRQ_MASK 8'h32
`define ADDR_LOOP_MODE_CONTROL 8'h34
`define ADDR_LOOP_BLEED_CONTROL 8'h35
`define ADDR_LOOP_CHARGE_PUMP 8'h36
`define ADDR_LOOP_PHASE_DETECTOR 8'h37
`define ADDR_LOOP_INTEGER_DIVIDER 8'h39
`define ADDR_LOOP_FRACTION_LOW 8'h3a
`define ADDR_LOOP_FRACTION_HIGH 8'h3b
`define ADDR_OUTPUT_DIVIDER 8'h40
`define ADDR_OUTPUT1_BUFFER_POWER 8'h41
`define ADDR_SYNTH_SOURCE_DIVIDER 8'h4d
`define ADDR_LOOP_REFERENCE_DIVIDER 8'h6a
`define ADDR_REF_GENERAL_CONTROL 8'h75
`define ADDR_REF_MASTER_CLOCK_MHZ_FIELD_A 8'h76
`define ADDR_REF_IRQ_ENABLE 8'h77
`define ADDR_REF_IRQ_MASK 8'h78
`define ADDR_REF_LOOP_MULTIPLIER 8'h7a
`define ADDR_SYNTH_IRQ_STATUS 8'hb0
`define ADDR_REF_IRQ_STATUS 8'hc9

// ----------------------------------------------------------------
// Status bit positions
// ----------------------------------------------------------------
`define REF_BIT_CAL_DONE 2
`define SYN_BIT_CLOCK_READY 6
`define SYN_BIT_CAL_DONE 5
`define SYN_BIT_OUT_OF_LOCK 3
`define SYN_BIT_IN_LOCK 2
`define SYN_BIT_RECAL 1

// ----------------------------------------------------------------
// Serial frame and reset values
// ----------------------------------------------------------------
`define FRAME_ADDR_BITS 5'h08
`define FRAME_NARROW_BITS 5'h08
`define FRAME_WIDE_BITS 5'h10
`define RESET_BYTE 8'h00
`define RESET_WORD 16'h0000

`endif

// ===== verilog/synth_pll_pkg.sv
// Types shared by the synthesizer control bank
`default_nettype none

package synth_pll_pkg;

    // Serial frame states
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_ADDR = 4'b0010,
        ST_DATA = 4'b0100,
        ST_READ = 4'b1000
    } frame_state_type;

    // Settings delivered to the analogue loops
    typedef struct packed {
        logic [7:0] ref_ctrl;
        logic [7:0] ref_mclk_mhz;
        logic [7:0] ref_mult;
        logic [15:0] synth_ctrl;
        logic source_select_field;
        logic [6:0] mhz_field_a;
        logic [7:0] source_div;
        logic [7:0] loop_mode;
        logic bleed_en;
        logic [6:0] bleed_bias;
        logic [7:0] bleed_set;
        logic [7:0] cp_bias;
        logic [7:0] cp_current;
        logic [7:0] phase_det;
        logic [15:0] int_div;
        logic [23:0] frac_div;
        logic [15:0] ref_div;
        logic [7:0] out_div;
        logic [7:0] output1_power;
    } synth_config_type;

endpackage : synth_pll_pkg

`default_nettype wire

// ===== verilog/pin_sync.sv
// Two-flop synchroniser with edge detection for the serial bus pins
`timescale 1ns/10ps
`default_nettype none

module pin_sync #(
    parameter int WIDTH = 3
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic [WIDTH-1:0] i_pins,
    output logic [WIDTH-1:0] o_level,
    output logic [WIDTH-1:0] o_rise,
    output logic [WIDTH-1:0] o_fall
);

    // ----------------------------------------------------------------
    // Per-pin stages
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : g_pin
            logic meta_r;
            logic sync_r;
            logic prev_r;
            always_ff @(posedge i_sys_clk) begin
                if (!i_rst_n) begin
                    meta_r <= 1'b1;
                    sync_r <= 1'b1;
                    prev_r <= 1'b1;
                end else begin
                    meta_r <= i_pins[g];
                    sync_r <= meta_r;
                    prev_r <= sync_r;
                end
            end
            assign o_level[g] = sync_r;
            assign o_rise[g] = sync_r & ~prev_r;
            assign o_fall[g] = ~sync_r & prev_r;
        end
    endgenerate

endmodule : pin_sync

`default_nettype wire

// ===== verilog/synth_pll_config_and_irq.sv
// Serial control bank, interrupt status and pin of the two-loop synthesizer
//
// Notes on behaviour
// - Reference enable 0x04 gates only calibration-complete
// - Masked-in enabled reference event pulls pin low
// - Synthesizer value 0x08 selects only out-of-lock
// - Out-of-lock alone: pin low only with bit3
// - Synthesizer enable 0x6e opens five sources together
// - Status reads report 0x40, 0x20, 0x04, 0x02, then 0x08
// - Status bit1 recalibrate, bit3 loss of lock
// - Reference control 0x0f enables every reference function
// - Synthesizer control 0x042b delivered unchanged to loops
// - Synthesizer control 0x0469 delivered unchanged to loops
// - Reference clock register splits megahertz and source
// - Source divider value is the ratio itself
// - Reference divider value equals its ratio
// - Fractional divider is signed two's complement
// - Output divider code passed through, 0x05 divides eight
// - Master clock register holds integer megahertz
// - Phase detector code passed through, 0x00 minimum
// - Bleed word splits enable, bias, set current
// - Charge pump word splits bias and current
`timescale 1ns/10ps
`default_nettype none
`include "synth_pll_cfg.svh"

module synth_pll_config_and_irq (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_bus_sclk,
    input wire logic i_bus_csn,
    input wire logic i_bus_cmd,
    input wire logic [7:0] i_ref_events,
    input wire logic [7:0] i_synth_events,
    output logic o_bus_reply,
    output logic o_interrupt_pin_n,
    output synth_pll_pkg::synth_config_type o_config
);

    // ----------------------------------------------------------------
    // Decode helpers
    // ----------------------------------------------------------------
    function automatic logic is_wide(input logic [7:0] a);
        is_wide = (a == `ADDR_SYNTH_GENERAL_CONTROL) || (a == `ADDR_LOOP_BLEED_CONTROL) ||
                  (a == `ADDR_LOOP_CHARGE_PUMP) || (a == `ADDR_LOOP_INTEGER_DIVIDER) ||
                  (a == `ADDR_LOOP_FRACTION_LOW) || (a == `ADDR_LOOP_REFERENCE_DIVIDER);
    endfunction : is_wide

    function automatic logic is_status(input logic [7:0] a);
        is_status = (a == `ADDR_SYNTH_IRQ_STATUS) || (a == `ADDR_REF_IRQ_STATUS);
    endfunction : is_status

    // ----------------------------------------------------------------
    // Pin synchronisation
    // ----------------------------------------------------------------
    logic [2:0] pin_level;
    logic [2:0] pin_rise;
    logic [2:0] pin_fall;

    pin_sync #(
        .WIDTH(3)
    ) u_pin_sync (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_pins({i_bus_sclk, i_bus_csn, i_bus_cmd}),
        .o_level(pin_level),
        .o_rise(pin_rise),
        .o_fall(pin_fall)
    );

    logic sclk_rise;
    logic sclk_fall;
    logic csn_high;
    logic csn_fall;
    logic cmd_bit;
    assign sclk_rise = pin_rise[2];
    assign sclk_fall = pin_fall[2];
    assign csn_high = pin_level[1];
    assign csn_fall = pin_fall[1];
    assign cmd_bit = pin_level[0];

    // ----------------------------------------------------------------
    // Frame state
    // ----------------------------------------------------------------
    synth_pll_pkg::frame_state_type state_r;
    synth_pll_pkg::frame_state_type state_nxt;
    logic [4:0] cnt_r;
    logic [4:0] cnt_nxt;
    logic [15:0] shift_r;
    logic [7:0] addr_r;
    logic [7:0] addr_nxt;
    logic [7:0] out_r;
    logic [7:0] out_nxt;
    logic reply_r;
    logic reply_nxt;
    logic wr_stb_r;
    logic wr_stb_nxt;
    logic [7:0] wr_addr_r;
    logic [15:0] wr_data_r;
    logic ref_clr;
    logic syn_clr;
    logic [7:0] ref_st_r;
    logic [7:0] syn_st_r;

    logic [7:0] addr_full;
    logic [15:0] data_full;
    logic [4:0] data_len;
    logic addr_last;
    logic data_last;
    assign addr_full = {shift_r[6:0], cmd_bit};
    assign data_full = {shift_r[14:0], cmd_bit};
    assign data_len = is_wide(addr_r) ? `FRAME_WIDE_BITS : `FRAME_NARROW_BITS;
    assign addr_last = (state_r == synth_pll_pkg::ST_ADDR) && sclk_rise && (cnt_r == `FRAME_ADDR_BITS - 5'h01);
    assign data_last = (state_r == synth_pll_pkg::ST_DATA) && sclk_rise && (cnt_r == data_len - 5'h01);

    assign ref_clr = addr_last && (addr_full == `ADDR_REF_IRQ_STATUS);
    assign syn_clr = addr_last && (addr_full == `ADDR_SYNTH_IRQ_STATUS);

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        addr_nxt = addr_r;
        out_nxt = out_r;
        reply_nxt = reply_r;
        wr_stb_nxt = 1'b0;
        if (csn_high) begin
            state_nxt = synth_pll_pkg::ST_IDLE;
            reply_nxt = 1'b0;
        end else if (csn_fall) begin
            state_nxt = synth_pll_pkg::ST_ADDR;
            cnt_nxt = 5'h00;
        end else begin
            unique case (state_r)
                synth_pll_pkg::ST_IDLE: begin
                end
                synth_pll_pkg::ST_ADDR: begin
                    if (sclk_rise) begin
                        cnt_nxt = cnt_r + 5'h01;
                    end
                    if (addr_last) begin
                        addr_nxt = addr_full;
                        cnt_nxt = 5'h00;
                        if (is_status(addr_full)) begin
                            out_nxt = (addr_full == `ADDR_REF_IRQ_STATUS) ? ref_st_r : syn_st_r;
                            reply_nxt = out_nxt[7];
                            state_nxt = synth_pll_pkg::ST_READ;
                        end else begin
                            state_nxt = synth_pll_pkg::ST_DATA;
                        end
                    end
                end
                synth_pll_pkg::ST_DATA: begin
                    if (sclk_rise) begin
                        cnt_nxt = cnt_r + 5'h01;
                    end
                    if (data_last) begin
                        wr_stb_nxt = 1'b1;
                        state_nxt = synth_pll_pkg::ST_IDLE;
                    end
                end
                synth_pll_pkg::ST_READ: begin
                    if (sclk_fall) begin
                        out_nxt = {out_r[6:0], 1'b0};
                        reply_nxt = out_r[7];
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            state_r <= synth_pll_pkg::ST_IDLE;
            cnt_r <= 5'h00;
            shift_r <= `RESET_WORD;
            addr_r <= `RESET_BYTE;
            out_r <= `RESET_BYTE;
            reply_r <= 1'b0;
            wr_stb_r <= 1'b0;
            wr_addr_r <= `RESET_BYTE;
            wr_data_r <= `RESET_WORD;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            if (sclk_rise) begin
                shift_r <= data_full;
            end
            addr_r <= addr_nxt;
            out_r <= out_nxt;
            reply_r <= reply_nxt;
            wr_stb_r <= wr_stb_nxt;
            if (data_last) begin
                wr_addr_r <= addr_r;
                wr_data_r <= is_wide(addr_r) ? data_full : {8'h00, data_full[7:0]};
            end
        end
    end

    assign o_bus_reply = reply_r;

    // ----------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------
    synth_pll_pkg::synth_config_type cfg_r;
    logic [7:0] ref_en_r;
    logic [7:0] ref_mask_r;
    logic [7:0] syn_en_r;
    logic [7:0] syn_mask_r;
    logic [7:0] frac_hi_r;

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            cfg_r <= '0;
            ref_en_r <= `RESET_BYTE;
            ref_mask_r <= `RESET_BYTE;
            syn_en_r <= `RESET_BYTE;
            syn_mask_r <= `RESET_BYTE;
            frac_hi_r <= `RESET_BYTE;
        end else if (wr_stb_r) begin
            case (wr_addr_r)
                `ADDR_REF_GENERAL_CONTROL: cfg_r.ref_ctrl <= wr_data_r[7:0];
                `ADDR_REF_MASTER_CLOCK_MHZ_FIELD_A: cfg_r.ref_mclk_mhz <= wr_data_r[7:0];
                `ADDR_REF_LOOP_MULTIPLIER: cfg_r.ref_mult <= wr_data_r[7:0];
                `ADDR_SYNTH_GENERAL_CONTROL: cfg_r.synth_ctrl <= wr_data_r;
                `ADDR_SYNTH_REF_CLOCK_MHZ_FIELD_A: {cfg_r.source_select_field, cfg_r.mhz_field_a} <= wr_data_r[7:0];
                `ADDR_SYNTH_SOURCE_DIVIDER: cfg_r.source_div <= wr_data_r[7:0];
                `ADDR_LOOP_MODE_CONTROL: cfg_r.loop_mode <= wr_data_r[7:0];
                `ADDR_LOOP_BLEED_CONTROL: {cfg_r.bleed_en, cfg_r.bleed_bias, cfg_r.bleed_set} <= wr_data_r;
                `ADDR_LOOP_CHARGE_PUMP: {cfg_r.cp_bias, cfg_r.cp_current} <= wr_data_r;
                `ADDR_LOOP_PHASE_DETECTOR: cfg_r.phase_det <= wr_data_r[7:0];
                `ADDR_LOOP_INTEGER_DIVIDER: cfg_r.int_div <= wr_data_r;
                `ADDR_LOOP_FRACTION_HIGH: frac_hi_r <= wr_data_r[7:0];
                `ADDR_LOOP_FRACTION_LOW: cfg_r.frac_div <= {frac_hi_r, wr_data_r};
                `ADDR_LOOP_REFERENCE_DIVIDER: cfg_r.ref_div <= wr_data_r;
                `ADDR_OUTPUT_DIVIDER: cfg_r.out_div <= wr_data_r[7:0];
                `ADDR_OUTPUT1_BUFFER_POWER: cfg_r.output1_power <= wr_data_r[7:0];
                `ADDR_REF_IRQ_ENABLE: ref_en_r <= wr_data_r[7:0];
                `ADDR_REF_IRQ_MASK: ref_mask_r <= wr_data_r[7:0];
                `ADDR_SYNTH_IRQ_ENABLE: syn_en_r <= wr_data_r[7:0];
                `ADDR_SYNTH_IRQ_MASK: syn_mask_r <= wr_data_r[7:0];
                default: begin
                end
            endcase
        end
    end

    assign o_config = cfg_r;

    // ----------------------------------------------------------------
    // Interrupt status and pin
    // ----------------------------------------------------------------
    logic [7:0] ref_st_nxt;
    logic [7:0] syn_st_nxt;
    logic pending;
    logic irq_n_r;

    // enable gating, set wins over read clear
    assign ref_st_nxt = (ref_st_r & ~{8{ref_clr}}) | (i_ref_events & ref_en_r);
    assign syn_st_nxt = (syn_st_r & ~{8{syn_clr}}) | (i_synth_events & syn_en_r);
    assign pending = |((ref_st_r & ref_mask_r) | (syn_st_r & syn_mask_r));

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            ref_st_r <= `RESET_BYTE;
            syn_st_r <= `RESET_BYTE;
            irq_n_r <= 1'b1;
        end else begin
            ref_st_r <= ref_st_nxt;
            syn_st_r <= syn_st_nxt;
            irq_n_r <= ~pending;
        end
    end

    assign o_interrupt_pin_n = irq_n_r;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    AST_REF_ENABLE_GATE: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        ((ref_st_r & ~$past(ref_st_r) & ~$past(ref_en_r)) == 8'h00))
        else $error("reference status bit set while disabled");

    AST_SYN_ENABLE_GATE: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        ((syn_st_r & ~$past(syn_st_r) & ~$past(syn_en_r)) == 8'h00))
        else $error("synthesizer status bit set while disabled");

    AST_PIN_LOW_ON_PENDING: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        ((ref_st_r & ref_mask_r) != 8'h00) |=> !o_interrupt_pin_n)
        else $error("pin not low for pending reference event");

    AST_PIN_ONLY_WITH_CAUSE: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        !o_interrupt_pin_n |-> $past(((ref_st_r & ref_mask_r) | (syn_st_r & syn_mask_r)) != 8'h00))
        else $error("pin low without masked-in status");

    AST_LOCK_LOSS_PIN: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (syn_st_r[`SYN_BIT_OUT_OF_LOCK] && syn_mask_r[`SYN_BIT_OUT_OF_LOCK]) |=> !o_interrupt_pin_n)
        else $error("loss of lock did not pull pin low");

    AST_READ_CLEARS: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (syn_clr && ((i_synth_events & syn_en_r) == 8'h00)) |=> (syn_st_r == 8'h00) ##1 o_interrupt_pin_n || (ref_st_r & ref_mask_r) != 8'h00)
        else $error("status read did not clear");

    AST_SET_WINS: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (ref_clr && ((i_ref_events & ref_en_r) != 8'h00)) |=> ((ref_st_r & $past(i_ref_events & ref_en_r)) != 8'h00))
        else $error("event lost on clearing read");

    AST_READ_FIRST_BIT: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        syn_clr |=> (o_bus_reply == $past(syn_st_r[7])) && (state_r == synth_pll_pkg::ST_READ))
        else $error("status readback bit wrong");

    AST_FRAC_WHOLE: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (wr_stb_r && wr_addr_r == `ADDR_LOOP_FRACTION_LOW) |=> (o_config.frac_div == {$past(frac_hi_r), $past(wr_data_r)}))
        else $error("fraction not loaded whole");

    AST_GCR_DELIVERED: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (wr_stb_r && wr_addr_r == `ADDR_SYNTH_GENERAL_CONTROL) |=> (o_config.synth_ctrl == $past(wr_data_r)))
        else $error("synthesizer control not delivered");

    AST_FRAME_COUNT: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (cnt_r <= `FRAME_WIDE_BITS))
        else $error("frame bit counter overran");

endmodule : synth_pll_config_and_irq

`default_nettype wire

// ===== test/host_bus_model.sv
// Host side of the serial control bus: frame writer and status reader
`timescale 1ns/10ps
`default_nettype none

module host_bus_model (
    input wire logic i_sys_clk,
    input wire logic i_reply,
    output logic o_sclk,
    output logic o_csn,
    output logic o_cmd
);
    logic [7:0] rd_data;

    initial begin
        o_sclk = 1'b0;
        o_csn = 1'b1;
        o_cmd = 1'b0;
        rd_data = 8'h00;
    end

    // ----------------------------------------------------------------
    // Bus cycles
    // ----------------------------------------------------------------
    task automatic wait_clk(input int n);
        repeat (n) @(negedge i_sys_clk);
    endtask : wait_clk

    // One 400 ns serial clock; reply sampled as the clock rises
    task automatic pulse(input logic b);
        o_cmd = b;
        wait_clk(4);
        rd_data = {rd_data[6:0], i_reply};
        o_sclk = 1'b1;
        wait_clk(4);
        o_sclk = 1'b0;
    endtask : pulse

    task automatic frame(input logic [7:0] addr, input logic [15:0] data, input int nbits);
        int i;
        o_csn = 1'b0;
        wait_clk(4);
        for (i = 7; i >= 0; i--) begin
            pulse(addr[i]);
        end
        for (i = nbits - 1; i >= 0; i--) begin
            pulse(data[i]);
        end
        // Released data line shows the inverse of its last value
        o_csn = 1'b1;
        o_cmd = ~o_cmd;
        wait_clk(6);
    endtask : frame

    // Word registers take 16 data bits, the rest 8
    task automatic wr(input logic [7:0] addr, input logic [15:0] data);
        logic wide;
        wide = addr inside {8'h2e, 8'h35, 8'h36, 8'h39, 8'h3a, 8'h6a};
        frame(addr, data, wide ? 16 : 8);
    endtask : wr
endmodule : host_bus_model

`default_nettype wire

// ===== test/test_synth_pll_config_and_irq.sv
// Self-checking bench for the synthesizer control bank
`timescale 1ns/10ps
`default_nettype none

module test_synth_pll_config_and_irq;
    logic i_sys_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic [7:0] ref_ev = 8'h00;
    logic [7:0] syn_ev = 8'h00;
    logic sclk;
    logic csn;
    logic cmd;
    logic reply;
    logic irq_n;
    synth_pll_pkg::synth_config_type cfg;
    int n_mismatch = 0;
    int cmp_count = 0;
    int cycles = 0;
    logic [7:0] wa [12] = '{8'h2f, 8'h4d, 8'h6a, 8'h34, 8'h35, 8'h36, 8'h37, 8'h39, 8'h40, 8'h31, 8'h32, 8'h2e};
    logic [15:0] wd [12] = '{16'h00f8, 16'h0008, 16'h0003, 16'h0002, 16'h8307, 16'h0525, 16'h0000, 16'h002e,
        16'h0005, 16'h0008, 16'h0008, 16'h042b};
    logic [7:0] seq [5] = '{8'h40, 8'h20, 8'h04, 8'h02, 8'h08};

    always #25 i_sys_clk = ~i_sys_clk;

    synth_pll_config_and_irq synth_pll_config_and_irq_i (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_bus_sclk(sclk),
        .i_bus_csn(csn),
        .i_bus_cmd(cmd),
        .i_ref_events(ref_ev),
        .i_synth_events(syn_ev),
        .o_bus_reply(reply),
        .o_interrupt_pin_n(irq_n),
        .o_config(cfg)
    );

    host_bus_model host_bus_model_i (
        .i_sys_clk(i_sys_clk),
        .i_reply(reply),
        .o_sclk(sclk),
        .o_csn(csn),
        .o_cmd(cmd)
    );

    // ----------------------------------------------------------------
    // Checking and closing
    // ----------------------------------------------------------------
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : tally_and_finish

    always @(posedge i_sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    // One-cycle loop event pulses, then the pin level
    task automatic ev(input logic [7:0] r, input logic [7:0] s, input logic pin);
        ref_ev = r;
        syn_ev = s;
        @(negedge i_sys_clk);
        ref_ev = 8'h00;
        syn_ev = 8'h00;
        repeat (3) @(negedge i_sys_clk);
        chk(irq_n, pin);
    endtask : ev

    // Status read; pin must be released afterwards
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        host_bus_model_i.frame(a, 16'h0000, 8);
        chk(host_bus_model_i.rd_data, e);
        chk(irq_n, 1'b1);
    endtask : rd

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        repeat (12) @(negedge i_sys_clk);
        chk(irq_n, 1'b1);
        chk(|cfg, 1'b0);
        i_rst_n = 1'b1;
        repeat (4) @(negedge i_sys_clk);
        host_bus_model_i.wr(8'h76, 16'h0026);
        host_bus_model_i.wr(8'h7a, 16'h0019);
        host_bus_model_i.wr(8'h77, 16'h0004);
        host_bus_model_i.wr(8'h78, 16'h0004);
        host_bus_model_i.wr(8'h75, 16'h000f);
        chk(cfg.ref_mclk_mhz, 8'h26);
        chk(cfg.ref_ctrl, 8'h0f);
        chk(cfg.ref_mult, 8'h19);
        ev(8'h07, 8'h00, 1'b0);
        rd(8'hc9, 8'h04);
        host_bus_model_i.wr(8'h78, 16'h0000);
        ev(8'h04, 8'h00, 1'b1);
        rd(8'hc9, 8'h04);
        // Event held across a clearing read survives it
        ref_ev = 8'h04;
        host_bus_model_i.frame(8'hc9, 16'h0000, 8);
        ref_ev = 8'h00;
        chk(host_bus_model_i.rd_data, 8'h04);
        rd(8'hc9, 8'h04);
        rd(8'hc9, 8'h00);
        $display("test reference loop done");
        // Synthesizer writes only after reference calibration seen, comparison 40 MHz
        for (int i = 0; i < 12; i++) begin
            host_bus_model_i.wr(wa[i], wd[i]);
        end
        chk({cfg.source_select_field, cfg.mhz_field_a}, 8'hf8);
        chk(cfg.source_div, 8'h08);
        chk(cfg.ref_div, 16'h0003);
        chk({cfg.bleed_en, cfg.bleed_bias, cfg.bleed_set}, 16'h8307);
        chk({cfg.cp_bias, cfg.cp_current}, 16'h0525);
        chk(cfg.phase_det, 8'h00);
        chk(cfg.out_div, 8'h05);
        chk(cfg.synth_ctrl, 16'h042b);
        chk(cfg.loop_mode, 8'h02);
        chk(cfg.mhz_field_a, 7'h78);
        host_bus_model_i.wr(8'h3b, 16'h0080);
        chk(cfg.frac_div, 24'h000000);
        host_bus_model_i.wr(8'h3a, 16'h0000);
        chk(cfg.frac_div, 24'h800000);
        chk(cfg.int_div, 16'h002e);
        $display("test synthesizer setup done");
        ev(8'h00, 8'h76, 1'b1);
        rd(8'hb0, 8'h00);
        ev(8'h00, 8'h08, 1'b0);
        rd(8'hb0, 8'h08);
        $display("test out of lock done");
        host_bus_model_i.wr(8'h31, 16'h006e);
        host_bus_model_i.wr(8'h32, 16'h006e);
        host_bus_model_i.wr(8'h2e, 16'h0469);
        chk(cfg.synth_ctrl, 16'h0469);
        host_bus_model_i.wr(8'h41, 16'h000c);
        chk(cfg.output1_power, 8'h0c);
        for (int i = 0; i < 5; i++) begin
            ev(8'h00, seq[i], 1'b0);
            rd(8'hb0, seq[i]);
        end
        ev(8'h00, 8'h91, 1'b1);
        rd(8'hb0, 8'h00);
        $display("test status sequence done");
        tally_and_finish();
    end
endmodule : test_synth_pll_config_and_irq

`default_nettype wire
